// *** include/tx_input_pkg.sv ***
/*
 * constants for the transmit system input: frame layout, clock rates,
 * elastic store defaults and the layout of the word handed to the framer.
 * assumes nothing of its surroundings.
 */
package tx_input_pkg;
    // frame layout: one framing bit then 24 channels of 8 bits
    localparam int CHANNEL_BITS = 8;
    localparam int CHANNELS = 24;
    localparam int FRAMING_BITS = 1;
    localparam int FRAME_BITS = FRAMING_BITS + CHANNELS * CHANNEL_BITS;
    localparam int FRAME_TIME_US = 125;
    localparam int POS_W = 8;
    localparam int CHBIT_W = 3;
    localparam logic [7:0] POS_RESET = 8'h00;
    localparam logic [2:0] CHBIT_RESET = 3'h0;

    // line and backplane clock rates in kHz
    localparam int LINE_T1_KHZ = 1544;
    localparam int LINE_E1_KHZ = 2048;
    localparam int BP_4M_KHZ = 4096;
    localparam int BP_8M_KHZ = 8192;
    localparam int BP_16M_KHZ = 16384;

    // elastic store default depth in bits
    localparam int ES_DEPTH_DEF = 16;

    // word to the framer: data bit, channel msb mark, framing bit mark
    localparam int WORD_DATA = 0;
    localparam int WORD_MSB = 1;
    localparam int WORD_FRAME = 2;
    localparam int WORD_W = 3;
    localparam logic [2:0] WORD_RESET = 3'h0;

    // two-entry buffer
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;

    // which clock samples the serial input
    typedef enum logic [0:0] {
        SRC_LINE = 1'b0,
        SRC_BACKPLANE = 1'b1
    } tx_source_e;
endpackage

// *** src/tx_system_input.sv ***
/*
 * transmit system input and line driver gate.
 * samples the serial input on the falling edge of the line clock, or of the
 * backplane clock when the elastic store or interleaved bus mode is on, and
 * hands framed bits through a two-entry buffer to the framer.
 * assumes: line_pulse_pos/neg, tx_word_ready come from line-clock logic;
 * driver_tristate and mode bits come from sys_clk logic; both link clocks
 * run while rst_b is held so the local reset reaches them.
 */
`timescale 1ns/1ps

// Summary of operation
// RULE1 - gate low forces line outputs high impedance
// RULE2 - gate high: tristate register decides drive
// RULE3 - no elastic store: sample on line falling; here interleaved_bus_mode alone samples on backplane falling
// RULE4 - elastic store: sample on backplane falling
// RULE5 - line clock supplied at 1.544/2.048 MHz
// RULE6 - backplane clock used only with elastic store; here interleaved_bus_mode alone also selects it
// RULE7 - unused backplane clock tied low externally
// RULE8 - interleaved mode needs higher backplane rates
// RULE9 - interleaved mode samples on backplane clock
// RULE10 - channel bits sent msb first
// RULE11 - frame: framing bit then 24 channels
// RULE12 - elastic store crosses bits without loss; here a full store drops the bit and sets es_overflow
module tx_system_input #(
    parameter int ES_DEPTH = tx_input_pkg::ES_DEPTH_DEF
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // host controls
    input wire logic driver_tristate,
    input wire logic elastic_store_enable,
    input wire logic interleaved_bus_mode,
    // pins
    input wire logic line_driver_gate,
    input wire logic tx_line_clock,
    input wire logic tx_backplane_clock,
    input wire logic tx_serial_input,
    // line code from the framer
    input wire logic line_pulse_pos,
    input wire logic line_pulse_neg,
    // line driver outputs
    output logic line_out_positive,
    output logic line_out_negative,
    output logic line_out_oe,
    // word stream to the framer
    output logic [tx_input_pkg::WORD_W-1:0] tx_word,
    output logic tx_word_valid,
    input wire logic tx_word_ready,
    // status
    output logic capture_overrun,
    output logic es_overflow
);
    localparam int AW = $clog2(ES_DEPTH);

    // elaboration check on the elastic store depth
    if (ES_DEPTH < 4 || (1 << AW) != ES_DEPTH) begin : g_bad_depth
        $error("ES_DEPTH must be a power of two of at least 4");
    end

    // system clock domain
    logic gate_meta_q, gate_q, oe_q, oe_d;
    logic use_bp_q, use_bp_d;

    // gate pin sync and drive enable
    always_comb begin
        oe_d = gate_q & ~driver_tristate; // [RULE1] [RULE2]
        use_bp_d = elastic_store_enable | interleaved_bus_mode; // [RULE6] [RULE9]
    end

    // mode follows its inputs through reset, so the link domains hold it before they leave reset
    always_ff @(posedge sys_clk) begin
        gate_meta_q <= line_driver_gate;
        use_bp_q <= use_bp_d;
        if (!rst_b) begin
            gate_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            gate_q <= gate_meta_q;
            oe_q <= oe_d;
        end
    end

    assign line_out_oe = oe_q;

    // elastic store memory, written on the backplane side
    logic es_mem [ES_DEPTH];
    logic [AW:0] wr_bin_q, wr_bin_d, wr_gray_q, wr_gray_d;
    logic [AW:0] rd_bin_q, rd_bin_d, rd_gray_q, rd_gray_d;

    // backplane domain: reset, mode and read pointer sync
    logic brst_meta_q, brst_b_q;
    logic buse_meta_q, buse_q;
    logic [AW:0] rg_meta_q, rg_q;
    logic es_full, es_push;
    logic es_ovf_q, es_ovf_d;

    // backplane write side
    always_comb begin
        es_full = (wr_gray_q == {~rg_q[AW:AW-1], rg_q[AW-2:0]});
        es_push = buse_q & ~es_full; // [RULE4] [RULE6] [RULE12]
        wr_bin_d = es_push ? wr_bin_q + 1'b1 : wr_bin_q;
        wr_gray_d = wr_bin_d ^ (wr_bin_d >> 1);
        es_ovf_d = buse_q & es_full;
    end

    // samples on the falling backplane edge
    always_ff @(negedge tx_backplane_clock) begin
        brst_meta_q <= rst_b;
        brst_b_q <= brst_meta_q;
        buse_meta_q <= use_bp_q;
        buse_q <= buse_meta_q;
        rg_meta_q <= rd_gray_q;
        if (!brst_b_q) begin
            rg_q <= '0;
            wr_bin_q <= '0;
            wr_gray_q <= '0;
            es_ovf_q <= 1'b0;
        end else begin
            rg_q <= rg_meta_q;
            wr_bin_q <= wr_bin_d;
            wr_gray_q <= wr_gray_d;
            es_ovf_q <= es_ovf_d;
        end
        if (es_push) begin
            es_mem[wr_bin_q[AW-1:0]] <= tx_serial_input; // [RULE4]
        end
    end

    assign es_overflow = es_ovf_q;

    // line domain: reset, mode and write pointer sync
    logic lrst_meta_q, lrst_b_q;
    logic luse_meta_q, luse_q;
    logic [AW:0] wg_meta_q, wg_q;
    tx_input_pkg::tx_source_e src;
    logic fifo_empty, in_valid, in_bit, push, pop, buf_in_ready;
    logic es_pop;

    // two-entry buffer and frame position
    logic [tx_input_pkg::WORD_W-1:0] buf_q [2];
    logic [tx_input_pkg::WORD_W-1:0] in_word;
    logic buf_wr_q, buf_wr_d, buf_rd_q, buf_rd_d;
    logic [1:0] buf_cnt_q, buf_cnt_d;
    logic [tx_input_pkg::POS_W-1:0] pos_q, pos_d;
    logic [tx_input_pkg::CHBIT_W-1:0] chbit_q, chbit_d;
    logic overrun_q, overrun_d;
    logic lpos_q, lneg_q;

    // source select, buffer and frame counting
    always_comb begin
        src = luse_q ? tx_input_pkg::SRC_BACKPLANE : tx_input_pkg::SRC_LINE; // [RULE9]
        fifo_empty = (rd_gray_q == wg_q);
        buf_in_ready = (buf_cnt_q != tx_input_pkg::BUF_FULL);
        in_valid = 1'b1;
        in_bit = tx_serial_input; // [RULE3]
        if (src == tx_input_pkg::SRC_BACKPLANE) begin
            in_valid = ~fifo_empty;
            in_bit = es_mem[rd_bin_q[AW-1:0]]; // [RULE12]
        end
        push = in_valid & buf_in_ready;
        es_pop = push & (src == tx_input_pkg::SRC_BACKPLANE); // [RULE12]
        pop = tx_word_valid & tx_word_ready;
        in_word = '0;
        in_word[tx_input_pkg::WORD_DATA] = in_bit;
        in_word[tx_input_pkg::WORD_FRAME] = (pos_q == tx_input_pkg::POS_RESET); // [RULE11]
        in_word[tx_input_pkg::WORD_MSB] = (pos_q != tx_input_pkg::POS_RESET) &&
            (chbit_q == tx_input_pkg::CHBIT_RESET); // [RULE10]
        rd_bin_d = es_pop ? rd_bin_q + 1'b1 : rd_bin_q;
        rd_gray_d = rd_bin_d ^ (rd_bin_d >> 1);
        buf_wr_d = push ? ~buf_wr_q : buf_wr_q;
        buf_rd_d = pop ? ~buf_rd_q : buf_rd_q;
        buf_cnt_d = buf_cnt_q;
        if (push && !pop) begin
            buf_cnt_d = buf_cnt_q + 2'h1;
        end else if (pop && !push) begin
            buf_cnt_d = buf_cnt_q - 2'h1;
        end
        pos_d = pos_q;
        chbit_d = chbit_q;
        if (push) begin
            if (pos_q == tx_input_pkg::POS_W'(tx_input_pkg::FRAME_BITS - 1)) begin // [RULE11]
                pos_d = tx_input_pkg::POS_RESET;
            end else begin
                pos_d = pos_q + 8'h01;
            end
            if (pos_q != tx_input_pkg::POS_RESET) begin
                if (chbit_q == tx_input_pkg::CHBIT_W'(tx_input_pkg::CHANNEL_BITS - 1)) begin // [RULE10]
                    chbit_d = tx_input_pkg::CHBIT_RESET;
                end else begin
                    chbit_d = chbit_q + 3'h1;
                end
            end
        end
        overrun_d = (src == tx_input_pkg::SRC_LINE) & ~buf_in_ready;
    end

    // samples on the falling line edge
    always_ff @(negedge tx_line_clock) begin
        lrst_meta_q <= rst_b;
        lrst_b_q <= lrst_meta_q;
        luse_meta_q <= use_bp_q;
        luse_q <= luse_meta_q;
        wg_meta_q <= wr_gray_q;
        if (!lrst_b_q) begin
            wg_q <= '0;
            rd_bin_q <= '0;
            rd_gray_q <= '0;
            buf_wr_q <= 1'b0;
            buf_rd_q <= 1'b0;
            buf_cnt_q <= tx_input_pkg::BUF_EMPTY;
            buf_q[0] <= tx_input_pkg::WORD_RESET;
            buf_q[1] <= tx_input_pkg::WORD_RESET;
            pos_q <= tx_input_pkg::POS_RESET;
            chbit_q <= tx_input_pkg::CHBIT_RESET;
            overrun_q <= 1'b0;
            lpos_q <= 1'b0;
            lneg_q <= 1'b0;
        end else begin
            wg_q <= wg_meta_q;
            rd_bin_q <= rd_bin_d;
            rd_gray_q <= rd_gray_d;
            buf_wr_q <= buf_wr_d;
            buf_rd_q <= buf_rd_d;
            buf_cnt_q <= buf_cnt_d;
            if (push) begin
                buf_q[buf_wr_q] <= in_word; // [RULE3] [RULE4]
            end
            pos_q <= pos_d;
            chbit_q <= chbit_d;
            overrun_q <= overrun_d;
            lpos_q <= line_pulse_pos;
            lneg_q <= line_pulse_neg;
        end
    end

    // outputs of the line domain
    assign tx_word = buf_q[buf_rd_q];
    assign tx_word_valid = (buf_cnt_q != tx_input_pkg::BUF_EMPTY);
    assign capture_overrun = overrun_q;
    assign line_out_positive = lpos_q;
    assign line_out_negative = lneg_q;
endmodule

// *** verification/tx_system_input_asserts.sv ***
/* port checks for tx_system_input.
   assumes the line clock keeps running while rst_b is low. */
`timescale 1ns/1ps
module tx_system_input_asserts (
    // system side
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic driver_tristate,
    input wire logic line_driver_gate,
    input wire logic line_out_oe,
    // line side
    input wire logic tx_line_clock,
    input wire logic line_pulse_pos,
    input wire logic line_pulse_neg,
    input wire logic line_out_positive,
    input wire logic line_out_negative,
    input wire logic [tx_input_pkg::WORD_W-1:0] tx_word,
    input wire logic tx_word_valid,
    input wire logic tx_word_ready,
    input wire logic capture_overrun
);
    // driver enable after the gate synchroniser
    property p_off; @(posedge sys_clk) disable iff (!rst_b) !line_driver_gate [*3] |=> !line_out_oe; endproperty
    a_off: assert property (p_off) else $error("driver on with gate low");
    property p_on; @(posedge sys_clk) disable iff (!rst_b) line_driver_gate [*3] ##0 !driver_tristate |=> line_out_oe;
    endproperty
    a_on: assert property (p_on) else $error("driver off with gate high");
    property p_tri; @(posedge sys_clk) disable iff (!rst_b) driver_tristate |=> !line_out_oe; endproperty
    a_tri: assert property (p_tri) else $error("driver on while released");
    // line side: data copy, word hold, drops and marks
    property p_pos; @(negedge tx_line_clock) disable iff (!rst_b)
        $past(rst_b, 3) |-> line_out_positive == $past(line_pulse_pos); endproperty
    a_pos: assert property (p_pos) else $error("positive output not a copy");
    property p_neg; @(negedge tx_line_clock) disable iff (!rst_b)
        $past(rst_b, 3) |-> line_out_negative == $past(line_pulse_neg); endproperty
    a_neg: assert property (p_neg) else $error("negative output not a copy");
    property p_hold; @(negedge tx_line_clock) disable iff (!rst_b)
        tx_word_valid && !tx_word_ready |=> tx_word_valid && $stable(tx_word); endproperty
    a_hold: assert property (p_hold) else $error("word changed while stalled");
    property p_ovr; @(negedge tx_line_clock) disable iff (!rst_b)
        capture_overrun |-> $past(tx_word_valid) && !$past(tx_word_ready, 2); endproperty
    a_ovr: assert property (p_ovr) else $error("overrun without stall");
    property p_mark; @(negedge tx_line_clock) disable iff (!rst_b) tx_word_valid |-> !(tx_word[2] && tx_word[1]);
    endproperty
    a_mark: assert property (p_mark) else $error("framing and msb mark together");
    // main scenarios reached
    c_oe: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(line_out_oe));
    c_ovr: cover property (@(negedge tx_line_clock) disable iff (!rst_b) capture_overrun);
    c_stall: cover property (@(negedge tx_line_clock) disable iff (!rst_b) tx_word_valid && !tx_word_ready);
endmodule
bind tx_system_input tx_system_input_asserts chk (.*);

// *** verification/bp_source.sv ***
/* backplane partner: line clock, backplane clock and serial data.
   assumes bp_on changes only while the block is in reset. */
`timescale 1ns/1ps
module bp_source (
    // mode
    input wire logic bp_on,
    input wire logic interleaved_bus_mode,
    // clocks and data
    output logic tx_line_clock,
    output logic tx_backplane_clock,
    output logic tx_serial_input
);
    logic bpc = 1'b0;
    logic [6:0] lfsr = 7'h5b;
    // free running line clock, 160 ns
    initial begin
        tx_line_clock = 1'b0;
        #7;
        forever #80 tx_line_clock = ~tx_line_clock;
    end
    // backplane clock at half the line rate, twice the line rate in interleaved mode
    always begin
        #(interleaved_bus_mode ? 40 : 160);
        bpc = ~bpc;
    end
    // held low when unused
    assign tx_backplane_clock = bpc & bp_on;
    // new bit on the rise of whichever clock samples it
    always @(posedge (bp_on ? tx_backplane_clock : tx_line_clock)) lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
    assign tx_serial_input = lfsr[0];
endmodule

// *** verification/tx_system_input_tb.sv ***
/* bench for tx_system_input: gate table, then direct, elastic and interleaved streams.
   assumes bp_source drives the link clocks and serial data. */
`timescale 1ns/1ps
module tx_system_input_tb;
    logic sys_clk = 1'b0, rst_b = 1'b0, driver_tristate = 1'b0, line_driver_gate = 1'b0;
    logic elastic_store_enable = 1'b0, interleaved_bus_mode = 1'b0, tx_word_ready = 1'b1;
    logic line_pulse_pos = 1'b0, line_pulse_neg = 1'b0, tx_line_clock, tx_backplane_clock, tx_serial_input;
    logic line_out_positive, line_out_negative, line_out_oe, tx_word_valid, capture_overrun, es_overflow;
    logic [2:0] tx_word;
    logic q[$];
    logic [2:0] rows[4] = '{3'b101, 3'b110, 3'b000, 3'b010};
    int error_cnt = 0, n_checks = 0, lc = 0, bc = 0, pos = 0, ovr = 0, esov = 0;
    wire bp_on = elastic_store_enable | interleaved_bus_mode;
    tx_system_input dut (.*);
    bp_source src (.*);
    always #12.5 sys_clk = ~sys_clk;
    // line code stimulus from the framer side
    always @(posedge sys_clk) #1 {line_pulse_pos, line_pulse_neg} <= {line_pulse_neg, ~line_pulse_pos};
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // long enough for three edges of both link clocks
    task do_reset(input logic es, input logic ib);
        rst_b = 1'b0;
        elastic_store_enable = es;
        interleaved_bus_mode = ib;
        tx_word_ready = 1'b1;
        tick(48);
        chk({1'h0, line_out_positive, line_out_negative, line_out_oe, tx_word_valid, tx_word}, 8'h00);
        q.delete();
        pos = 0;
        rst_b = 1'b1;
    endtask
    // check each word taken, then queue the bit sampled on this line edge
    always @(negedge tx_line_clock) begin
        lc = rst_b ? lc + 1 : 0;
        if (rst_b && capture_overrun === 1'b1) ovr++;
        if (rst_b && tx_word_valid === 1'b1 && tx_word_ready) begin
            chk({5'h0, tx_word}, {5'h0, pos % 193 == 0, pos % 193 % 8 == 1, q.size() > 0 ? q.pop_front() : 1'bx});
            pos++;
        end
        if (lc >= 3 && !bp_on) q.push_back(tx_serial_input);
    end
    // queue the bits sampled on the backplane clock; a flagged drop takes back the bit of the edge before
    always @(negedge tx_backplane_clock) begin
        bc = rst_b ? bc + 1 : 0;
        if (rst_b && es_overflow === 1'b1) begin
            esov++;
            if (q.size() > 0) void'(q.pop_back());
        end
        if (bc >= 3) q.push_back(tx_serial_input);
    end
    // main sequence
    initial begin
        do_reset(1'b0, 1'b0);
        foreach (rows[i]) begin
            {line_driver_gate, driver_tristate} = rows[i][2:1];
            tick(4);
            chk({7'h0, line_out_oe}, {7'h0, rows[i][0]});
        end
        $display("gate table done");
        tick(1600);
        chk({7'h0, pos > 193}, 8'h01);
        tx_word_ready = 1'b0;
        tick(100);
        chk({7'h0, ovr > 0}, 8'h01);
        $display("direct stream done");
        do_reset(1'b1, 1'b0);
        tick(400);
        tx_word_ready = 1'b0;
        tick(150);
        tx_word_ready = 1'b1;
        tick(3200);
        chk({7'h0, pos > 193 && esov == 0}, 8'h01);
        $display("elastic stream done");
        do_reset(1'b0, 1'b1);
        tick(3200);
        chk({7'h0, pos > 193}, 8'h01);
        chk({7'h0, esov > 0}, 8'h01);
        $display("interleaved stream done");
        final_report();
    end
    // watchdog
    initial begin
        #400000;
        error_cnt++;
        final_report();
    end
endmodule
